// [design/sfcm_pkg.sv]
// sfcm_pkg: register map, field positions, reset values and timing constants
// for the serial flow control and modem pin block.
// assumes an 8-bit register port and a 100 MHz device clock.
package sfcm_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int CNT_W = 4;
    localparam int NUM_MODEM_IN = 4;
    localparam int FIFO_DEPTH = 12;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CHAN_OPT_TWO = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CHAN_OPT_THREE = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_MODEM_OPT_ONE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_MODEM_OPT_TWO = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_MODEM_SIG_ONE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MODEM_SIG_TWO = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_MODEM_CHANGE = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_RESUME_CHAR = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STOP_CHAR = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_FLOW_STATUS = 4'hA;

    // field positions
    localparam int BIT_IMPLIED_RESUME = 7;
    localparam int BIT_AUTO_TX_INBAND = 6;
    localparam int BIT_AUTO_REQUEST_OUT = 2;
    localparam int BIT_AUTO_CLEAR_GATE = 1;
    localparam int BIT_TRANSPARENT_FC = 5;
    localparam int BIT_PAIR_DETECT = 4;
    localparam int BIT_THRESH_LSB = 0;
    localparam int BIT_RISE_EN_LSB = 4;
    localparam int BIT_FALL_EN_LSB = 0;
    localparam int BIT_MANUAL_RTS = 0;
    localparam int BIT_MANUAL_DTR = 1;
    localparam int BIT_INPUT_LSB = 4;
    localparam int BIT_MODEM_IRQ_EN = 7;

    // reset values
    localparam logic [DATA_W-1:0] RST_REG = 8'h00;
    localparam logic [CNT_W-1:0] THRESH_OFF = 4'h0;

    // input scan: sampled once per period, well inside the 2 ms budget
    localparam int CLK_MHZ = 100;
    localparam int SCAN_PERIOD_US = 1000;
    localparam int SCAN_CYC = SCAN_PERIOD_US * CLK_MHZ;
endpackage : sfcm_pkg

// [design/sfcm_pin_scan.sv]
// sfcm_pin_scan: synchronises the modem inputs and scans them periodically
// for changes against the last stored sample.
// assumes asynchronous pins; one device clock.
`timescale 1ns/1ps
module sfcm_pin_scan #(
    parameter int WIDTH = 4,
    parameter int SCAN_CYCLES = 100000
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stored;
    logic [31:0] scan_cnt;
    logic scan_tick;

    initial begin
        if (SCAN_CYCLES < 2 || WIDTH < 1) begin
            $error("sfcm_pin_scan: bad parameters");
        end
    end

    // first stage feeds only the second
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '0;
            level_o <= '0;
        end else begin
            meta <= pin_i;
            level_o <= meta;
        end
    end

    assign scan_tick = (scan_cnt == 32'(SCAN_CYCLES - 1));

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scan_cnt <= '0;
        end else if (scan_tick) begin
            scan_cnt <= '0;
        end else begin
            scan_cnt <= scan_cnt + 32'h1;
        end
    end

    // sampled, not latched: pulses shorter than a scan period may be missed
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stored <= '0;
            rise_o <= '0;
            fall_o <= '0;
        end else if (scan_tick) begin
            stored <= level_o;
            rise_o <= level_o & ~stored;
            fall_o <= ~level_o & stored;
        end else begin
            rise_o <= '0;
            fall_o <= '0;
        end
    end
endmodule : sfcm_pin_scan

// [design/sfcm_top.sv]
// Contract
// - pair match only when detect enable set
// - transparent mode consumes flow characters, not stored
// - in-band transmit stop only when enabled
// - implied resume lets any character but a matched stop char restart
// - four-bit receive threshold, levels 0 to 12
// - zero threshold leaves ready line manual
// - ready asserted while count below threshold
// - manual ready bit one asserts ready
// - auto request asserted while transmit data pending
// - clear gate stops new characters, resumes later
// - clear checked at FIFO to holding move
// - special send ignores clear and set-ready
// - clear and set-ready readable in signal one
// - signal bits inverted against pin level
// - edge enables set change bits, request service
// - inputs scanned periodically, latency under 2 ms
// - four modem pins usable as general I/O
// - pair detect enable is option three bit 4
// - transparent enable is option three bit 5
// - without implied resume only resume char restarts
// - stop char halts after current and holding
//
// sfcm_top: out-of-band and in-band flow control plus modem pin registers.
// assumes the transmitter asks before moving a FIFO character to holding.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sfcm_top
#(
    parameter int SCAN_CYCLES = sfcm_pkg::SCAN_CYC,
    parameter int RX_FIFO_DEPTH = sfcm_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [sfcm_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [sfcm_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [sfcm_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic rx_enable_i,
    input wire logic [sfcm_pkg::CNT_W-1:0] rx_fifo_count_i,
    input wire logic rx_char_valid_i,
    input wire logic [sfcm_pkg::DATA_W-1:0] rx_char_i,
    output logic rx_store_o,
    output logic [sfcm_pkg::DATA_W-1:0] rx_store_data_o,
    input wire logic tx_fifo_empty_i,
    input wire logic tx_busy_i,
    output logic tx_load_allow_o,
    input wire logic send_special_i,
    output logic tx_special_go_o,
    input wire logic cts_n_i,
    input wire logic dsr_n_i,
    input wire logic cd_n_i,
    input wire logic ri_n_i,
    output logic rts_n_o,
    output logic dtr_n_o,
    output logic modem_service_request_n_o
);
    import sfcm_pkg::*;

    logic [DATA_W-1:0] chan_opt_two;
    logic [DATA_W-1:0] chan_opt_three;
    logic [DATA_W-1:0] modem_opt_one;
    logic [DATA_W-1:0] modem_opt_two;
    logic manual_rts;
    logic manual_dtr;
    logic [NUM_MODEM_IN-1:0] modem_change;
    logic irq_en;
    logic [DATA_W-1:0] resume_char;
    logic [DATA_W-1:0] stop_char;
    logic tx_stopped;
    logic [NUM_MODEM_IN-1:0] in_level;
    logic [NUM_MODEM_IN-1:0] in_rise;
    logic [NUM_MODEM_IN-1:0] in_fall;
    logic [NUM_MODEM_IN-1:0] in_view;
    logic [CNT_W-1:0] rx_handshake_threshold;
    logic implied_resume_mode;
    logic auto_tx_inband_en;
    logic auto_request_out_en;
    logic auto_clear_gate_en;
    logic transparent_flowctl_en;
    logic special_char_pair_detect_en;
    logic cts_on;
    logic is_resume;
    logic is_stop;
    logic next_dtr_on;
    logic next_rts_on;

    initial begin
        if (RX_FIFO_DEPTH < 1 || RX_FIFO_DEPTH > 15 || SCAN_CYCLES < 2) begin
            $error("sfcm_top: bad parameters");
        end
    end

    function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
        wr_hit = reg_wr_i && (reg_addr_i == ofs);
    endfunction : wr_hit

    assign implied_resume_mode = chan_opt_two[BIT_IMPLIED_RESUME];
    assign auto_tx_inband_en = chan_opt_two[BIT_AUTO_TX_INBAND];
    assign auto_request_out_en = chan_opt_two[BIT_AUTO_REQUEST_OUT];
    assign auto_clear_gate_en = chan_opt_two[BIT_AUTO_CLEAR_GATE];
    assign transparent_flowctl_en = chan_opt_three[BIT_TRANSPARENT_FC];
    assign special_char_pair_detect_en = chan_opt_three[BIT_PAIR_DETECT];
    assign rx_handshake_threshold = modem_opt_one[BIT_THRESH_LSB +: CNT_W];

    // pins active low; logical level 1 means asserted
    sfcm_pin_scan #(
        .WIDTH(NUM_MODEM_IN),
        .SCAN_CYCLES(SCAN_CYCLES)
    ) u_scan (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pin_i({~ri_n_i, ~cd_n_i, ~dsr_n_i, ~cts_n_i}),
        .level_o(in_level),
        .rise_o(in_rise),
        .fall_o(in_fall)
    );
    assign cts_on = in_level[0];
    // read view puts cts and dsr in the top two bits, then cd and ri
    assign in_view = {in_level[0], in_level[1], in_level[2], in_level[3]};

    // register writes
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chan_opt_two <= RST_REG;
            chan_opt_three <= RST_REG;
            modem_opt_one <= RST_REG;
            modem_opt_two <= RST_REG;
            manual_rts <= 1'b0;
            manual_dtr <= 1'b0;
            irq_en <= 1'b0;
            resume_char <= RST_REG;
            stop_char <= RST_REG;
        end else begin
            if (wr_hit(OFS_CHAN_OPT_TWO)) chan_opt_two <= reg_wdata_i;
            if (wr_hit(OFS_CHAN_OPT_THREE)) chan_opt_three <= reg_wdata_i;
            if (wr_hit(OFS_MODEM_OPT_ONE)) modem_opt_one <= reg_wdata_i;
            if (wr_hit(OFS_MODEM_OPT_TWO)) modem_opt_two <= reg_wdata_i;
            if (wr_hit(OFS_MODEM_SIG_ONE)) manual_rts <= reg_wdata_i[BIT_MANUAL_RTS];
            if (wr_hit(OFS_MODEM_SIG_TWO)) manual_dtr <= reg_wdata_i[BIT_MANUAL_DTR];
            if (wr_hit(OFS_IRQ_ENABLE)) irq_en <= reg_wdata_i[BIT_MODEM_IRQ_EN];
            if (wr_hit(OFS_RESUME_CHAR)) resume_char <= reg_wdata_i;
            if (wr_hit(OFS_STOP_CHAR)) stop_char <= reg_wdata_i;
        end
    end

    // change bits: write one clears, a new edge in the same cycle wins
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            modem_change <= '0;
        end else begin
            modem_change <= (modem_change
                & ~(wr_hit(OFS_MODEM_CHANGE) ? reg_wdata_i[NUM_MODEM_IN-1:0] : '0))
                | (in_rise & modem_opt_one[BIT_RISE_EN_LSB +: NUM_MODEM_IN])
                | (in_fall & modem_opt_two[BIT_FALL_EN_LSB +: NUM_MODEM_IN]);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            modem_service_request_n_o <= 1'b1;
        end else begin
            modem_service_request_n_o <= ~(irq_en && (|modem_change));
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= RST_REG;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_CHAN_OPT_TWO: reg_rdata_o <= chan_opt_two;
                OFS_CHAN_OPT_THREE: reg_rdata_o <= chan_opt_three;
                OFS_MODEM_OPT_ONE: reg_rdata_o <= modem_opt_one;
                OFS_MODEM_OPT_TWO: reg_rdata_o <= modem_opt_two;
                OFS_MODEM_SIG_ONE: reg_rdata_o <= {in_view, 3'h0, ~rts_n_o};
                OFS_MODEM_SIG_TWO: reg_rdata_o <= {in_view, 2'h0, ~dtr_n_o, 1'b0};
                OFS_MODEM_CHANGE: reg_rdata_o <= {4'h0, modem_change};
                OFS_IRQ_ENABLE: reg_rdata_o <= {irq_en, 7'h00};
                OFS_RESUME_CHAR: reg_rdata_o <= resume_char;
                OFS_STOP_CHAR: reg_rdata_o <= stop_char;
                OFS_FLOW_STATUS: reg_rdata_o <= {7'h00, tx_stopped};
                default: reg_rdata_o <= RST_REG;
            endcase
        end else begin
            reg_rdata_o <= RST_REG;
        end
    end

    // in-band character matching
    assign is_resume = special_char_pair_detect_en && (rx_char_i == resume_char);
    assign is_stop = special_char_pair_detect_en && (rx_char_i == stop_char);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_stopped <= 1'b0;
        end else if (!auto_tx_inband_en) begin
            tx_stopped <= 1'b0;
        end else if (rx_char_valid_i) begin
            if (is_stop) begin
                tx_stopped <= 1'b1;
            end else if (is_resume || implied_resume_mode) begin
                tx_stopped <= 1'b0;
            end
        end
    end

    // flow characters are consumed only when transparent and matched, even with in-band transmit control off
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_store_o <= 1'b0;
            rx_store_data_o <= RST_REG;
        end else begin
            rx_store_o <= rx_char_valid_i
                && !(transparent_flowctl_en && (is_stop || is_resume));
            rx_store_data_o <= rx_char_i;
        end
    end

    // gating applies to FIFO-to-holding moves only, so current and holding
    // characters always finish after a stop
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_load_allow_o <= 1'b0;
        end else begin
            tx_load_allow_o <= !tx_stopped && (!auto_clear_gate_en || cts_on);
        end
    end

    // special sends bypass every pin check
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_special_go_o <= 1'b0;
        end else begin
            tx_special_go_o <= send_special_i;
        end
    end

    always_comb begin
        if (rx_handshake_threshold != THRESH_OFF && rx_enable_i) begin
            next_dtr_on = rx_fifo_count_i < rx_handshake_threshold;
        end else begin
            next_dtr_on = manual_dtr;
        end
        if (auto_request_out_en) begin
            next_rts_on = !tx_fifo_empty_i || tx_busy_i;
        end else begin
            next_rts_on = manual_rts;
        end
    end

    // outputs drive low when asserted
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dtr_n_o <= 1'b1;
            rts_n_o <= 1'b1;
        end else begin
            dtr_n_o <= ~next_dtr_on;
            rts_n_o <= ~next_rts_on;
        end
    end

    property p_dtr_full;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (rx_handshake_threshold != 4'h0 && rx_enable_i
            && rx_fifo_count_i >= rx_handshake_threshold) |=> dtr_n_o;
    endproperty
    a_dtr_full: assert property (p_dtr_full) else $error("ready not dropped at threshold");

    property p_dtr_room;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (rx_handshake_threshold != 4'h0 && rx_enable_i
            && rx_fifo_count_i < rx_handshake_threshold) |=> !dtr_n_o;
    endproperty
    a_dtr_room: assert property (p_dtr_room) else $error("ready not asserted below threshold");

    property p_dtr_manual;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (rx_handshake_threshold == 4'h0) |=> (dtr_n_o == !$past(manual_dtr));
    endproperty
    a_dtr_manual: assert property (p_dtr_manual) else $error("ready not under host control");

    property p_rts_auto;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (auto_request_out_en && !tx_fifo_empty_i) |=> !rts_n_o;
    endproperty
    a_rts_auto: assert property (p_rts_auto) else $error("request not asserted with data");

    property p_cts_gate;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (auto_clear_gate_en && !cts_on) |=> !tx_load_allow_o;
    endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("load allowed without clear");

    property p_stop_char;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (rx_char_valid_i && special_char_pair_detect_en && auto_tx_inband_en
            && rx_char_i == stop_char) |=> ##1 !tx_load_allow_o;
    endproperty
    a_stop_char: assert property (p_stop_char) else $error("stop char did not halt loads");

    property p_discard;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (rx_char_valid_i && special_char_pair_detect_en && transparent_flowctl_en
            && rx_char_i == stop_char) |=> !rx_store_o;
    endproperty
    a_discard: assert property (p_discard) else $error("flow char stored in transparent mode");

    property p_no_detect;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (rx_char_valid_i && !special_char_pair_detect_en) |=> rx_store_o;
    endproperty
    a_no_detect: assert property (p_no_detect) else $error("char dropped without detect");

    property p_special;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        send_special_i |=> tx_special_go_o;
    endproperty
    a_special: assert property (p_special) else $error("special send was gated");

    property p_service;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        (irq_en && |modem_change) |=> !modem_service_request_n_o;
    endproperty
    a_service: assert property (p_service) else $error("service request missing");
endmodule : sfcm_top

// [tb/sfcm_remote_modem.sv]
// sfcm_remote_modem: far-side modem on the handshake pins
// assumes the bench sets the wanted input levels; pins are always driven
`timescale 1ns/1ps
module sfcm_remote_modem (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic rts_n_i,
    input wire logic follow_i,
    input wire logic [3:0] delay_i,
    input wire logic [3:0] want_i,
    output logic cts_n_o,
    output logic dsr_n_o,
    output logic cd_n_o,
    output logic ri_n_o
);
    logic [15:0] hist;

    // request history, so clear can answer promptly or slowly
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hist <= 16'hFFFF;
        end else begin
            hist <= {hist[14:0], rts_n_i};
        end
    end

    // pins idle deasserted (high) out of reset
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cts_n_o <= 1'b1;
            dsr_n_o <= 1'b1;
            cd_n_o <= 1'b1;
            ri_n_o <= 1'b1;
        end else begin
            cts_n_o <= follow_i ? hist[delay_i] : ~want_i[0];
            dsr_n_o <= ~want_i[1];
            cd_n_o <= ~want_i[2];
            ri_n_o <= ~want_i[3];
        end
    end
endmodule : sfcm_remote_modem

// [tb/test_serial_flow_control_modem.sv]
// test_serial_flow_control_modem: register-level tests of sfcm_top
// assumes sfcm_pkg compiled first; scan period shortened to 16 cycles
`timescale 1ns/1ps
module test_serial_flow_control_modem;
    import sfcm_pkg::*;
    localparam int LIMIT = 8000;
    logic sys_clk_i = 1'b0, rstn_i = 1'b0;
    logic [3:0] addr = 4'h0, rx_cnt = 4'h0, dly = 4'h1, want = 4'h0;
    logic [7:0] wdata = 8'h00, rx_char = 8'h00, rdata, rx_data, rv;
    logic wr = 1'b0, rd = 1'b0, rx_en = 1'b0, rx_valid = 1'b0, tx_empty = 1'b1;
    logic tx_busy = 1'b0, special = 1'b0, follow = 1'b0;
    logic rx_store, allow, go, cts_n, dsr_n, cd_n, ri_n, rts_n, dtr_n, svc_n;
    int n_fail = 0, n_checks = 0, cycles = 0, i, j;

    always #5 sys_clk_i = ~sys_clk_i;

    sfcm_top #(.SCAN_CYCLES(16), .RX_FIFO_DEPTH(12)) dut (.sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_enable_i(rx_en), .rx_fifo_count_i(rx_cnt),
        .rx_char_valid_i(rx_valid), .rx_char_i(rx_char), .rx_store_o(rx_store),
        .rx_store_data_o(rx_data), .tx_fifo_empty_i(tx_empty), .tx_busy_i(tx_busy),
        .tx_load_allow_o(allow), .send_special_i(special), .tx_special_go_o(go),
        .cts_n_i(cts_n), .dsr_n_i(dsr_n), .cd_n_i(cd_n), .ri_n_i(ri_n), .rts_n_o(rts_n),
        .dtr_n_o(dtr_n), .modem_service_request_n_o(svc_n));

    sfcm_remote_modem remote (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .rts_n_i(rts_n),
        .follow_i(follow), .delay_i(dly), .want_i(want), .cts_n_o(cts_n),
        .dsr_n_o(dsr_n), .cd_n_o(cd_n), .ri_n_o(ri_n));

    task final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // a hang counts as a mismatch
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            final_report();
        end
    end

    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task pin_chk(input string what, input logic seen, input logic exp);
        check(what, {7'h00, seen}, {7'h00, exp});
    endtask : pin_chk

    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : cyc

    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        rv = rdata;
        check(what, rv, exp);
    endtask : rd_chk

    task rx_send(input logic [7:0] c, input logic st, input logic stop);
        @(posedge sys_clk_i);
        rx_valid <= 1'b1;
        rx_char <= c;
        @(posedge sys_clk_i);
        rx_valid <= 1'b0;
        #1;
        pin_chk("rx store", rx_store, st);
        if (st) begin
            check("rx store data", rx_data, c);
        end
        rd_chk(OFS_FLOW_STATUS, {7'h00, stop}, "tx stopped");
        pin_chk("load allow", allow, ~stop);
    endtask : rx_send

    initial begin
        repeat (3) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        #1;
        pin_chk("rts idle", rts_n, 1'b1);
        pin_chk("dtr idle", dtr_n, 1'b1);
        pin_chk("svc idle", svc_n, 1'b1);
        pin_chk("allow in reset", allow, 1'b0);
        cyc(2);
        pin_chk("allow after reset", allow, 1'b1);
        for (i = 0; i < 16; i++) rd_chk(i[3:0], 8'h00, "reset value");
        for (i = 10; i < 16; i++) wr_reg(i[3:0], 8'hFF);
        for (i = 10; i < 16; i++) rd_chk(i[3:0], 8'h00, "read-only or unmapped");
        $display("test registers done");

        rx_en <= 1'b1;
        cyc(3);
        pin_chk("dtr zero threshold", dtr_n, 1'b1);
        wr_reg(OFS_MODEM_SIG_TWO, 8'h02);
        cyc(2);
        pin_chk("dtr manual", dtr_n, 1'b0);
        rd_chk(OFS_MODEM_SIG_TWO, 8'h02, "signal two");
        wr_reg(OFS_MODEM_SIG_TWO, 8'h00);
        // thresholds at the bottom level 1 and the top one at 12
        for (i = 1; i <= 12; i += 11) begin
            wr_reg(OFS_MODEM_OPT_ONE, {4'h0, i[3:0]});
            rx_cnt <= i[3:0] - 4'h1;
            cyc(3);
            pin_chk("dtr below", dtr_n, 1'b0);
            rx_cnt <= i[3:0];
            cyc(3);
            pin_chk("dtr at threshold", dtr_n, 1'b1);
            rx_cnt <= i[3:0] - 4'h1;
            cyc(3);
            pin_chk("dtr falls below", dtr_n, 1'b0);
        end
        rx_en <= 1'b0;
        cyc(3);
        pin_chk("dtr receiver off", dtr_n, 1'b1);
        wr_reg(OFS_MODEM_OPT_ONE, 8'h00);
        rx_cnt <= 4'h0;
        $display("test receive handshake done");

        wr_reg(OFS_MODEM_SIG_ONE, 8'h01);
        cyc(2);
        pin_chk("rts manual", rts_n, 1'b0);
        rd_chk(OFS_MODEM_SIG_ONE, 8'h01, "signal one rts");
        wr_reg(OFS_MODEM_SIG_ONE, 8'h00);
        wr_reg(OFS_CHAN_OPT_TWO, 8'h04);
        tx_empty <= 1'b0;
        cyc(3);
        pin_chk("rts data", rts_n, 1'b0);
        tx_empty <= 1'b1;
        tx_busy <= 1'b1;
        cyc(3);
        pin_chk("rts sending", rts_n, 1'b0);
        tx_busy <= 1'b0;
        cyc(3);
        pin_chk("rts empty", rts_n, 1'b1);
        $display("test request out done");

        follow <= 1'b1;
        wr_reg(OFS_CHAN_OPT_TWO, 8'h06);
        for (i = 0; i < 2; i++) begin
            dly <= (i == 0) ? 4'h1 : 4'hC;
            cyc(24);
            pin_chk("allow without clear", allow, 1'b0);
            rd_chk(OFS_MODEM_SIG_ONE, 8'h00, "signal one idle");
            @(posedge sys_clk_i);
            special <= 1'b1;
            @(posedge sys_clk_i);
            special <= 1'b0;
            #1;
            pin_chk("special go", go, 1'b1);
            tx_empty <= 1'b0;
            j = 0;
            while (allow !== 1'b1 && j < 40) begin
                cyc(1);
                j++;
            end
            pin_chk("allow with clear", allow, 1'b1);
            pin_chk("clear not early", j > dly, 1'b1);
            rd_chk(OFS_MODEM_SIG_ONE, 8'h81, "signal one clear");
            tx_empty <= 1'b1;
        end
        follow <= 1'b0;
        wr_reg(OFS_CHAN_OPT_TWO, 8'h00);
        $display("test clear gate done");

        wr_reg(OFS_STOP_CHAR, 8'h13);
        wr_reg(OFS_RESUME_CHAR, 8'h11);
        rd_chk(OFS_STOP_CHAR, 8'h13, "stop char");
        rd_chk(OFS_RESUME_CHAR, 8'h11, "resume char");
        wr_reg(OFS_CHAN_OPT_TWO, 8'h40);
        rx_send(8'h13, 1'b1, 1'b0);
        wr_reg(OFS_CHAN_OPT_THREE, 8'h10);
        wr_reg(OFS_CHAN_OPT_TWO, 8'h00);
        rx_send(8'h13, 1'b1, 1'b0);
        wr_reg(OFS_CHAN_OPT_TWO, 8'h40);
        rx_send(8'h13, 1'b1, 1'b1);
        rx_send(8'h41, 1'b1, 1'b1);
        rx_send(8'h11, 1'b1, 1'b0);
        wr_reg(OFS_CHAN_OPT_THREE, 8'h30);
        rx_send(8'h13, 1'b0, 1'b1);
        rx_send(8'h11, 1'b0, 1'b0);
        wr_reg(OFS_CHAN_OPT_TWO, 8'hC0);
        rd_chk(OFS_CHAN_OPT_TWO, 8'hC0, "option two");
        rx_send(8'h13, 1'b0, 1'b1);
        rx_send(8'h41, 1'b1, 1'b0);
        wr_reg(OFS_CHAN_OPT_TWO, 8'h00);
        wr_reg(OFS_CHAN_OPT_THREE, 8'h00);
        $display("test in-band done");

        wr_reg(OFS_MODEM_OPT_ONE, 8'hF0);
        wr_reg(OFS_IRQ_ENABLE, 8'h80);
        rd_chk(OFS_IRQ_ENABLE, 8'h80, "irq enable");
        for (i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            want[i] <= 1'b1;
            j = 0;
            while (svc_n !== 1'b0 && j < 40) begin
                cyc(1);
                j++;
            end
            pin_chk("service request", svc_n, 1'b0);
            rd_chk(OFS_MODEM_CHANGE, 8'h01 << i, "change rise");
            rd_chk(OFS_MODEM_SIG_ONE, {want[0], want[1], want[2], want[3], 4'h0},
                "inputs");
            wr_reg(OFS_MODEM_CHANGE, 8'h01 << i);
            cyc(3);
            pin_chk("service cleared", svc_n, 1'b1);
        end
        wr_reg(OFS_MODEM_OPT_TWO, 8'h0F);
        wr_reg(OFS_IRQ_ENABLE, 8'h00);
        want <= 4'h0;
        cyc(40);
        pin_chk("service masked", svc_n, 1'b1);
        rd_chk(OFS_MODEM_CHANGE, 8'h0F, "change fall");
        wr_reg(OFS_MODEM_CHANGE, 8'h0F);
        rd_chk(OFS_MODEM_CHANGE, 8'h00, "change cleared");
        $display("test modem change done");
        final_report();
    end
endmodule : test_serial_flow_control_modem
